// ==== include/srac_params.svh ====
/*
 * Register offsets, field positions and reset values for the consequent
 * action controller. Assumes inclusion by bare name from rtl/ sources.
 */
`ifndef SRAC_PARAMS_SVH
`define SRAC_PARAMS_SVH

// printed offsets are indices, byte address is four times the index
`define SRAC_IDX_RDI_EXT       8'h93
`define SRAC_IDX_LINE_AIS_DEFECT_CTRL     8'h94
`define SRAC_IDX_ERDI_CTRL     8'h92
`define SRAC_ADDR_RDI_EXT      10'h24c
`define SRAC_ADDR_LINE_AIS_DEFECT_CTRL    10'h250
`define SRAC_ADDR_ERDI_CTRL    10'h248
`define SRAC_ADDR_STATUS       10'h300

// extension register fields
`define SRAC_EXT_AISC_RDI      7
`define SRAC_EXT_AISC_ERDI     6
`define SRAC_EXT_GLOBAL        2
`define SRAC_EXT_UNEQ_RDI      1
`define SRAC_EXT_UNEQ_ERDI     0
`define SRAC_EXT_RESET         8'h03
`define SRAC_EXT_RD_MASK       8'hc3

// enhanced rdi control fields
`define SRAC_ER_LCD            7
`define SRAC_ER_ALM            6
`define SRAC_ER_PAIS           5
`define SRAC_ER_LABEL_MISMATCH           4
`define SRAC_ER_LOP            3
`define SRAC_ER_PTR_CONCAT_LOSS         2
`define SRAC_ER_TIU            1
`define SRAC_ER_TIM            0
`define SRAC_ER_RESET          8'h11

// line ais control fields
`define SRAC_LA_SD             7
`define SRAC_LA_SF             6
`define SRAC_LA_LOF            5
`define SRAC_LA_LOS            4
`define SRAC_LA_TIM            3
`define SRAC_LA_TIU            2
`define SRAC_LA_DCC            0
`define SRAC_LA_RESET          8'h30
`define SRAC_LA_RD_MASK        8'hfd

// g1 bits 5..7 codes, bit 5 msb of the triple
`define SRAC_G1_NONE           3'h0
`define SRAC_G1_CONN           3'h2
`define SRAC_G1_SERVER         3'h5
`define SRAC_G1_PAYLOAD        3'h6
`define SRAC_G1_RDI            3'h4

`endif

// ==== include/srac_pkg.sv ====
/*
 * Types for the consequent action controller.
 * Assumes srac_params.svh is on the include path.
 */
package srac_pkg;
	// receive side defect levels, one per detector
	typedef struct packed {
		logic signal_loss;
		logic frame_loss;
		logic line_ais_defect;
		logic ptr_loss;
		logic ptr_concat_loss;
		logic path_ais;
		logic ais_concat_event;
		logic label_mismatch;
		logic unequipped;
		logic cell_delin_loss;
		logic trace_unstable;
		logic trace_mismatch;
		logic sec_trace_unstable;
		logic sec_trace_mismatch;
		logic signal_fail;
		logic signal_degrade;
	} srac_defects_t;

	typedef enum logic [1:0] {
		SRAC_CLS_NONE,
		SRAC_CLS_LOW,
		SRAC_CLS_HIGH
	} srac_class_t;
endpackage

// ==== rtl/srac_consequent_ctrl.sv ====
/*
 * Consequent action controller: maps receive defects onto path rdi and
 * enhanced rdi codes for transmitted g1, and onto receive line ais and
 * dcc all-ones. Registers on an ahb-lite slave. Assumes defect inputs
 * and frame_start are synchronous to hclk and come from detectors
 * elsewhere; frame_start pulses once per frame.
 */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "srac_params.svh"

module srac_consequent_ctrl
	import srac_pkg::*;
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire srac_defects_t defects,
	input  wire logic          frame_start,
	input  wire logic          section_dcc_in,
	input  wire logic          line_dcc_in,
	output logic      [2:0]    g1_rdi_bits,
	output logic               path_rdi,
	output logic               rx_line_ais,
	output logic               section_dcc_out,
	output logic               line_dcc_out
);

	logic [7:0]  ext_ctrl;
	logic [7:0]  erdi_ctrl;
	logic [7:0]  line_ais_defect_ctrl;
	logic        wr_pend;
	logic [9:0]  wr_addr;
	logic        rd_pend;
	logic [9:0]  rd_addr;
	logic        enhanced_rdi_global_en;
	logic        ptr_concat_loss_erdi_en;
	logic        ptr_loss_erdi_en;
	logic        label_mismatch_erdi_en;
	logic        path_ais_erdi_en;
	logic        line_alarm_erdi_en;
	logic        cell_delin_loss_erdi_en;
	logic        trace_unstable_erdi_en;
	logic        trace_mismatch_erdi_en;
	logic        unequipped_erdi_en;
	logic        unequipped_rdi_en;
	logic        ais_concat_erdi_en;
	logic        ais_concat_rdi_en;
	logic        dcc_all_ones_en;
	logic        trace_unstable_ais_en;
	logic        trace_mismatch_ais_en;
	logic        signal_loss_ais_en;
	logic        frame_loss_ais_en;
	logic        signal_fail_ais_en;
	logic        signal_degrade_ais_en;
	logic        line_alarm;
	logic        hi_cause;
	logic        lo_cause;
	srac_class_t next_class;
	logic [2:0]  next_g1;
	logic        next_rdi;
	logic        next_ais;
	logic [31:0] next_rdata;
	logic        addr_ok;

	// register fields, named by what they steer
	assign enhanced_rdi_global_en  = ext_ctrl[`SRAC_EXT_GLOBAL];
	assign ais_concat_rdi_en       = ext_ctrl[`SRAC_EXT_AISC_RDI];
	assign ais_concat_erdi_en      = ext_ctrl[`SRAC_EXT_AISC_ERDI];
	assign unequipped_rdi_en       = ext_ctrl[`SRAC_EXT_UNEQ_RDI];
	assign unequipped_erdi_en      = ext_ctrl[`SRAC_EXT_UNEQ_ERDI];
	assign cell_delin_loss_erdi_en = erdi_ctrl[`SRAC_ER_LCD];
	assign line_alarm_erdi_en      = erdi_ctrl[`SRAC_ER_ALM];
	assign path_ais_erdi_en        = erdi_ctrl[`SRAC_ER_PAIS];
	assign label_mismatch_erdi_en  = erdi_ctrl[`SRAC_ER_LABEL_MISMATCH];
	assign ptr_loss_erdi_en        = erdi_ctrl[`SRAC_ER_LOP];
	assign ptr_concat_loss_erdi_en = erdi_ctrl[`SRAC_ER_PTR_CONCAT_LOSS];
	assign trace_unstable_erdi_en  = erdi_ctrl[`SRAC_ER_TIU];
	assign trace_mismatch_erdi_en  = erdi_ctrl[`SRAC_ER_TIM];
	assign signal_degrade_ais_en   = line_ais_defect_ctrl[`SRAC_LA_SD];
	assign signal_fail_ais_en      = line_ais_defect_ctrl[`SRAC_LA_SF];
	assign frame_loss_ais_en       = line_ais_defect_ctrl[`SRAC_LA_LOF];
	assign signal_loss_ais_en      = line_ais_defect_ctrl[`SRAC_LA_LOS];
	assign trace_mismatch_ais_en   = line_ais_defect_ctrl[`SRAC_LA_TIM];
	assign trace_unstable_ais_en   = line_ais_defect_ctrl[`SRAC_LA_TIU];
	assign dcc_all_ones_en         = line_ais_defect_ctrl[`SRAC_LA_DCC];

	// server-class causes, all share code 01 in bits 6,7
	assign line_alarm = defects.signal_loss | defects.frame_loss
		| defects.line_ais_defect;
	always_comb begin
		hi_cause = 1'b0;
		hi_cause = hi_cause | (ptr_concat_loss_erdi_en
			& defects.ptr_concat_loss);
		hi_cause = hi_cause | (ptr_loss_erdi_en & defects.ptr_loss);
		hi_cause = hi_cause | (path_ais_erdi_en & defects.path_ais);
		hi_cause = hi_cause | (line_alarm_erdi_en & line_alarm);
		hi_cause = hi_cause | (ais_concat_erdi_en
			& defects.ais_concat_event);
	end

	// payload and connectivity causes, code 10 in bits 6,7
	always_comb begin
		lo_cause = 1'b0;
		lo_cause = lo_cause | (label_mismatch_erdi_en
			& defects.label_mismatch);
		lo_cause = lo_cause | (cell_delin_loss_erdi_en
			& defects.cell_delin_loss);
		lo_cause = lo_cause | (unequipped_erdi_en
			& defects.unequipped);
		lo_cause = lo_cause | (trace_mismatch_erdi_en
			& defects.trace_mismatch);
		lo_cause = lo_cause | (trace_unstable_erdi_en
			& defects.trace_unstable);
	end

	// class choice and g1 code; the server class wins outright
	always_comb begin
		next_class = SRAC_CLS_NONE;
		if (hi_cause) begin
			next_class = SRAC_CLS_HIGH;
		end else if (lo_cause) begin
			next_class = SRAC_CLS_LOW;
		end
		if (!enhanced_rdi_global_en) begin
			next_class = SRAC_CLS_NONE;
		end
		case (next_class)
			SRAC_CLS_HIGH: next_g1 = `SRAC_G1_SERVER;
			SRAC_CLS_LOW:  next_g1 = `SRAC_G1_PAYLOAD;
			default:       next_g1 = `SRAC_G1_NONE;
		endcase
	end

	// plain path rdi causes held in the extension register
	always_comb begin
		next_rdi = 1'b0;
		next_rdi = next_rdi | (unequipped_rdi_en
			& defects.unequipped);
		next_rdi = next_rdi | (ais_concat_rdi_en
			& defects.ais_concat_event);
	end

	// receive line ais causes
	always_comb begin
		next_ais = 1'b0;
		next_ais = next_ais | (trace_unstable_ais_en
			& defects.sec_trace_unstable);
		next_ais = next_ais | (trace_mismatch_ais_en
			& defects.sec_trace_mismatch);
		next_ais = next_ais | (signal_loss_ais_en
			& defects.signal_loss);
		next_ais = next_ais | (frame_loss_ais_en
			& defects.frame_loss);
		next_ais = next_ais | (signal_fail_ais_en
			& defects.signal_fail);
		next_ais = next_ais | (signal_degrade_ais_en
			& defects.signal_degrade);
	end

	// g1 code and path rdi change only on frame boundaries so a
	// transmitted overhead byte never carries a half-updated code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			g1_rdi_bits <= `SRAC_G1_NONE;
			path_rdi    <= 1'b0;
		end else if (frame_start) begin
			g1_rdi_bits <= next_g1;
			path_rdi    <= next_rdi;
		end
	end

	// line ais follows defects every clock; downstream aligns to frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_line_ais <= 1'b0;
		end else begin
			rx_line_ais <= next_ais;
		end
	end

	// dcc all-ones, registered to keep outputs off combinational paths
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			section_dcc_out <= 1'b0;
			line_dcc_out    <= 1'b0;
		end else begin
			section_dcc_out <= section_dcc_in | (dcc_all_ones_en
				& (defects.signal_loss | defects.frame_loss));
			line_dcc_out    <= line_dcc_in | (dcc_all_ones_en
				& line_alarm);
		end
	end

	// ahb address phase capture; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 10'h000;
			rd_addr <= 10'h000;
		end else if (hready) begin
			wr_pend <= hsel & htrans[1] & hwrite;
			rd_pend <= hsel & htrans[1] & ~hwrite;
			wr_addr <= haddr[9:0];
			rd_addr <= haddr[9:0];
		end
	end

	// register writes in the data phase; unmapped writes are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_ctrl  <= `SRAC_EXT_RESET;
			erdi_ctrl <= `SRAC_ER_RESET;
			line_ais_defect_ctrl <= `SRAC_LA_RESET;
		end else if (wr_pend) begin
			case (wr_addr)
				`SRAC_ADDR_RDI_EXT:   ext_ctrl  <= hwdata[7:0] & 8'hc7;
				`SRAC_ADDR_ERDI_CTRL: erdi_ctrl <= hwdata[7:0];
				`SRAC_ADDR_LINE_AIS_DEFECT_CTRL: line_ais_defect_ctrl <= hwdata[7:0] & 8'hfd;
				default: ;
			endcase
		end
	end

	// read mux; the global enable is write-only and reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		addr_ok = 1'b1;
		case (haddr[9:0])
			`SRAC_ADDR_RDI_EXT:
				next_rdata[7:0] = ext_ctrl & `SRAC_EXT_RD_MASK;
			`SRAC_ADDR_ERDI_CTRL:
				next_rdata[7:0] = erdi_ctrl;
			`SRAC_ADDR_LINE_AIS_DEFECT_CTRL:
				next_rdata[7:0] = line_ais_defect_ctrl & `SRAC_LA_RD_MASK;
			`SRAC_ADDR_STATUS:
				next_rdata[7:0] = {2'h0, line_dcc_out, section_dcc_out,
					rx_line_ais, g1_rdi_bits[1:0] == 2'h0 ? path_rdi :
					path_rdi, g1_rdi_bits[1:0]};
			default:
				addr_ok = 1'b0;
		endcase
	end

	// read data registered at the address phase, valid in data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite && addr_ok) begin
				hrdata <= next_rdata;
			end else if (hready) begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

endmodule

// ==== verif/srac_monitor.sv ====
/* port checker for the consequent controller.
 assumes a bind onto srac_consequent_ctrl, single clock hclk. */
`timescale 1ns/1ps
`include "srac_params.svh"
module srac_monitor
	import srac_pkg::*;
(
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire srac_defects_t defects,
	input wire logic          frame_start,
	input wire logic          section_dcc_in,
	input wire logic          line_dcc_in,
	input wire logic [2:0]    g1_rdi_bits,
	input wire logic          path_rdi,
	input wire logic          rx_line_ais,
	input wire logic          section_dcc_out,
	input wire logic          line_dcc_out
);
	wire srv;
	wire ais_src;
	// server class causes and receive ais causes
	assign srv = defects.signal_loss | defects.frame_loss |
		defects.line_ais_defect | defects.ptr_loss |
		defects.ptr_concat_loss | defects.path_ais | defects.ais_concat_event;
	assign ais_src = defects.signal_loss | defects.frame_loss |
		defects.sec_trace_unstable | defects.sec_trace_mismatch |
		defects.signal_fail | defects.signal_degrade;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_srv;
		frame_start ##1 (g1_rdi_bits == `SRAC_G1_SERVER);
	endsequence
	property p_g1_hold; !frame_start |=> $stable(g1_rdi_bits); endproperty
	a_g1_hold: assert property (p_g1_hold) else $error("g1 moved");
	property p_rdi_hold; !frame_start |=> $stable(path_rdi); endproperty
	a_rdi_hold: assert property (p_rdi_hold) else $error("rdi moved");
	property p_code;
		g1_rdi_bits inside {`SRAC_G1_NONE, `SRAC_G1_SERVER, `SRAC_G1_PAYLOAD};
	endproperty
	a_code: assert property (p_code) else $error("bad g1 code");
	property p_idle; frame_start && defects == '0 |=> g1_rdi_bits == 3'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("g1 without cause");
	property p_srv; s_srv |-> $past(srv); endproperty
	a_srv: assert property (p_srv) else $error("server no cause");
	property p_rdi_src;
		frame_start && !defects.unequipped && !defects.ais_concat_event
			|=> !path_rdi;
	endproperty
	a_rdi_src: assert property (p_rdi_src) else $error("stray rdi");
	property p_sdcc; section_dcc_in |=> section_dcc_out; endproperty
	a_sdcc: assert property (p_sdcc) else $error("sdcc lost");
	property p_sdcc0;
		!section_dcc_in && !defects.signal_loss && !defects.frame_loss
			|=> !section_dcc_out;
	endproperty
	a_sdcc0: assert property (p_sdcc0) else $error("sdcc forced");
	property p_ldcc0;
		!line_dcc_in && !defects.signal_loss && !defects.frame_loss &&
			!defects.line_ais_defect |=> !line_dcc_out;
	endproperty
	a_ldcc0: assert property (p_ldcc0) else $error("ldcc forced");
	property p_ais0; !ais_src |=> !rx_line_ais; endproperty
	a_ais0: assert property (p_ais0) else $error("stray ais");
endmodule

// ==== verif/srac_far_end.sv ====
/* far-end terminal model: frame timing and dcc bit streams.
 assumes one hclk domain and an active-low reset. */
`timescale 1ns/1ps
module srac_far_end #(
	parameter int FRAME = 16
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	output logic      frame_start,
	output logic      section_dcc_in,
	output logic      line_dcc_in
);
	logic [7:0] cnt;
	// short frame keeps the run brief
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= 8'h00;
		else if (frame_start)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end
	assign frame_start = (cnt == 8'(FRAME - 1));
	// dcc bits alternate so stuck forced ones show up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			section_dcc_in <= 1'b0;
			line_dcc_in <= 1'b1;
		end else begin
			section_dcc_in <= ~section_dcc_in;
			line_dcc_in <= ~line_dcc_in;
		end
	end
endmodule

// ==== verif/testbench.sv ====
/* self-checking bench: ahb-lite master tasks, defect tables.
 assumes the far-end model supplies frame_start and dcc bits. */
`timescale 1ns/1ps
`include "srac_params.svh"
module testbench
	import srac_pkg::*;
;
	logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]   haddr, hwdata, hrdata, rd;
	logic [1:0]    htrans;
	logic [2:0]    hsize, g1;
	logic          fs, sdi, ldi, prdi, ais, sdo, ldo;
	srac_defects_t dfx;
	int            n_mismatch, n_tests, cyc;
	logic [31:0]   gc [14] = '{32'h04040800, 32'h08041000, 32'h10040100,
		32'h20040400, 32'h40044000, 32'h80040040, 32'h18041100,
		32'h08001000, 32'h00050080, 32'h00020080, 32'h10440300,
		32'h00800200, 32'h01040010, 32'h00040100};
	logic [3:0]    ge [14] = '{4'ha, 4'ha, 4'hc, 4'ha, 4'ha, 4'hc, 4'ha,
		4'h0, 4'hc, 4'h1, 4'ha, 4'h1, 4'hc, 4'h0};
	logic [23:0]   lc [7] = '{24'h108000, 24'h204000, 24'h400002,
		24'h800001, 24'h040008, 24'h080004, 24'h00c000};
	logic [6:0]    le = 7'b0111111;
	srac_consequent_ctrl u_srac_consequent_ctrl(.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .defects(dfx), .frame_start(fs),
		.section_dcc_in(sdi), .line_dcc_in(ldi), .g1_rdi_bits(g1),
		.path_rdi(prdi), .rx_line_ais(ais), .section_dcc_out(sdo),
		.line_dcc_out(ldo));
	srac_far_end u_srac_far_end(.hclk(hclk), .hresetn(hresetn),
		.frame_start(fs), .section_dcc_in(sdi), .line_dcc_in(ldi));
	// free-running bus clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// address phase held until hready, read data taken at data edge
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd);
		// response must stay okay on every read, mapped or not
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task frm;
		do @(posedge hclk); while (fs !== 1'b1);
		#1;
	endtask
	// hang guard
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		dfx = '0;
		cyc = 0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("erdi rst", 32'h248, 32'h11);
		rdc("ext rst", 32'h24c, 32'h03);
		rdc("line_ais_defect rst", 32'h250, 32'h30);
		rdc("unmapped", 32'h200, 32'h0);
		ahb(1'b1, 32'h24c, 32'hff);
		rdc("ext wr", 32'h24c, 32'hc3);
		ahb(1'b1, 32'h250, 32'hff);
		rdc("line_ais_defect wr", 32'h250, 32'hfd);
		$display("register test done");
		for (int i = 0; i < 14; i++) begin
			ahb(1'b1, 32'h248, {24'h0, gc[i][31:24]});
			ahb(1'b1, 32'h24c, {24'h0, gc[i][23:16]});
			@(posedge hclk);
			dfx <= srac_defects_t'(gc[i][15:0]);
			frm();
			chk("g1", 32'(ge[i][3:1]), 32'(g1));
			chk("path_rdi", 32'(ge[i][0]), 32'(prdi));
			// status view of path rdi and g1 bits 6,7 while defects hold
			ahb(1'b0, 32'h300, 32'h0);
			chk("status", 32'({ge[i][0], ge[i][2:1]}), rd & 32'h7);
			@(posedge hclk);
			dfx <= '0;
			frm();
			chk("g1 clear", 32'h0, 32'(g1));
		end
		$display("rdi test done");
		for (int i = 0; i < 7; i++) begin
			ahb(1'b1, 32'h250, {24'h0, lc[i][23:16]});
			@(posedge hclk);
			dfx <= srac_defects_t'(lc[i][15:0]);
			@(posedge hclk);
			#1;
			chk("ais on", 32'(le[i]), 32'(ais));
			@(posedge hclk);
			dfx <= '0;
			@(posedge hclk);
			#1;
			chk("ais off", 32'h0, 32'(ais));
		end
		$display("ais test done");
		ahb(1'b1, 32'h250, 32'h01);
		@(posedge hclk);
		dfx <= srac_defects_t'(16'h8000);
		repeat (2) begin
			@(posedge hclk);
			#1;
			chk("sdcc ones", 32'h1, 32'(sdo));
			chk("ldcc ones", 32'h1, 32'(ldo));
		end
		dfx <= srac_defects_t'(16'h2000);
		@(posedge hclk);
		repeat (2) begin
			@(posedge hclk);
			#1;
			chk("ldcc line_ais_defect", 32'h1, 32'(ldo));
		end
		$display("dcc test done");
		complete_run();
	end
endmodule
bind srac_consequent_ctrl srac_monitor u_srac_monitor(.hclk(hclk),
	.hresetn(hresetn), .defects(defects), .frame_start(frame_start),
	.section_dcc_in(section_dcc_in), .line_dcc_in(line_dcc_in),
	.g1_rdi_bits(g1_rdi_bits), .path_rdi(path_rdi),
	.rx_line_ais(rx_line_ais), .section_dcc_out(section_dcc_out),
	.line_dcc_out(line_dcc_out));
